// [src/spm_regs.sv]
// Serial port mode, data and status registers with chip-select control
//
// Overview of operation
// - Master-select bit chooses master or slave
// - Select from mode field or each write
// - Decoding drives encoded value, fifteen peripherals
// - Decoded selects use settings in groups of four
// - Mode faults ignored while disable bit set
// - Loopback routes output to input as master
// - Plain mode: field maps to one low line
// - Decoded mode: lines equal the field
// - Inter-select delay, at least six cycles
// - Received character right-justified, upper bits zero
// - Master records select lines; slave reads zero
// - Last-transfer bit releases select after character when select comes from each write
// - Receive-full sets on load, clears on read
// - Transmit-empty set on move, zero when disabled
// - Mode-fault flag sets, clears on status read
// - Overrun on second load without read
// - Count-done flags follow counters reaching zero
// - Slave-select rising edge sets sticky flag
// - Idle flag clears on write, sets when drained
// - Enable-state bit shows port enabled
// - Mode fault disables port until re-enabled
//
// Chosen here: the register addresses and the address-and-strobe port.
module spm_regs #(
  parameter int ADDR_W = spm_pkg::ADDR_W
) (
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [31:0]       wdata,
  input  wire logic              wr_en,
  input  wire logic              rd_en,
  output logic [31:0]            rdata,
  output logic                   irq,
  input  wire logic              spck_in,
  output logic                   spck_out,
  output logic                   spck_oe,
  input  wire logic              mosi_in,
  output logic                   mosi_out,
  output logic                   mosi_oe,
  input  wire logic              miso_in,
  output logic                   miso_out,
  output logic                   miso_oe,
  input  wire logic              nss_in,
  output logic [3:0]             cs_n_out,
  output logic                   cs_oe
);
  import spm_pkg::*;

  if (ADDR_W < spm_pkg::ADDR_W) begin : g_chk
    $error("ADDR_W too small for the register map");
  end

  spm_shift_if sh ();
  spm_state_t  st_r;
  logic        enable_r;
  logic [31:0] mode_r;
  logic [31:0] sel_r [4];
  logic [9:0]  imask_r;
  logic [15:0] tx_data_r;
  logic [3:0]  tx_pcs_r;
  logic        tx_last_r;
  logic        tx_full_r;
  logic [15:0] rx_data_r;
  logic [3:0]  rx_pcs_r;
  logic        rx_full_r;
  logic        ovr_r;
  logic        mode_fault_flag_r;
  logic        slave_select_rising_r;
  logic        txidle_r;
  logic [3:0]  cs_r;
  logic [1:0]  cur_grp_r;
  logic        cur_hold_r;
  logic        cur_last_r;
  logic [7:0]  dly_r;
  logic [15:0] cnt_r [2];
  logic [15:0] ncnt_r [2];
  logic [3:0]  s1_r;
  logic [3:0]  s2_r;
  logic        nss_prev_r;
  logic [1:0]  cs0_q_r;
  logic [31:0] rdata_r;
  logic        irq_r;
  logic        spck_oe_r;
  logic        mosi_oe_r;
  logic        miso_oe_r;
  logic        cs_oe_r;

  logic        master_select, ps, dec, mode_fault_disable, local_loopback;
  logic [3:0]  mr_pcs;
  logic [7:0]  dly_val;
  logic        wr_ctrl, wr_tx, rd_rx, rd_flags, soft_rst;
  logic        nss_s, nss_fall, nss_rise;
  logic [3:0]  new_pcs, new_cs;
  logic [1:0]  new_grp;
  logic        go_m, start_m, desel_m, start_s, start_any;
  logic        mode_fault_flag_ev, rx_load, end_desel;
  logic [9:0]  flags;
  logic [1:0]  cnt_ev;
  logic [31:0] sel_cur;

  // Mode word fields
  assign master_select    = mode_r[MODE_MASTER_SELECT];
  assign ps      = mode_r[MODE_PS];
  assign dec     = mode_r[MODE_DEC];
  assign mode_fault_disable = mode_r[MODE_MODE_FAULT_DISABLE];
  assign local_loopback     = mode_r[MODE_LLB];
  assign mr_pcs  = mode_r[MODE_PCS_LO +: 4];
  // Short programmed delays are stretched to the floor value
  assign dly_val = (mode_r[MODE_DLY_LO +: 8] <= MIN_DLY) ? MIN_DLY
                                                        : mode_r[MODE_DLY_LO +: 8];

  // Bus decode
  assign wr_ctrl  = wr_en && addr == OFF_CTRL;
  assign wr_tx    = wr_en && addr == OFF_TX;
  assign rd_rx    = rd_en && addr == OFF_RX;
  assign rd_flags = rd_en && addr == OFF_FLAGS;
  assign soft_rst = wr_ctrl && wdata[CTRL_SWRST];

  // Plain mode yields one low line; decoded mode passes the field through
  function automatic logic [3:0] cs_map(input logic [3:0] p, input logic d);
    if (d) return p;
    else if (!p[0]) return 4'hE;
    else if (!p[1]) return 4'hD;
    else if (!p[2]) return 4'hB;
    else if (!p[3]) return 4'h7;
    else return CS_NONE;
  endfunction

  // Which settings word serves a select value
  function automatic logic [1:0] grp_of(input logic [3:0] p, input logic d);
    if (d) return p[3:2];
    else if (!p[0]) return 2'h0;
    else if (!p[1]) return 2'h1;
    else if (!p[2]) return 2'h2;
    else return 2'h3;
  endfunction

  // Fixed select from the mode word, variable from each data write
  assign new_pcs = ps ? tx_pcs_r : mr_pcs;
  assign new_cs  = cs_map(new_pcs, dec);
  assign new_grp = grp_of(new_pcs, dec);
  // An idle master looks ahead, so a new character starts with its own settings
  assign sel_cur = sel_r[!master_select ? 2'h0 : (st_r == ST_IDLE) ? new_grp : cur_grp_r];

  // Pin synchronisers; only the second stage is read
  always_ff @(posedge clk) begin
    if (!resetn) begin
      s1_r       <= 4'hF;
      s2_r       <= 4'hF;
      nss_prev_r <= 1'b1;
    end else begin
      s1_r       <= {nss_in, spck_in, mosi_in, miso_in};
      s2_r       <= s1_r;
      nss_prev_r <= s2_r[3];
    end
  end
  assign nss_s    = s2_r[3];
  assign nss_fall = nss_prev_r && !nss_s;
  assign nss_rise = !nss_prev_r && nss_s;

  // A fault is only an outside driver while our own line 0 sits released
  assign mode_fault_flag_ev = enable_r && master_select && !mode_fault_disable && !nss_s
                   && cs_r[0] && (&cs0_q_r);

  // Start and release decisions
  assign go_m      = enable_r && master_select && st_r == ST_IDLE && tx_full_r && !sh.busy;
  assign desel_m   = go_m && cs_r != CS_NONE && cs_r != new_cs;
  assign start_m   = go_m && (cs_r == new_cs || (cs_r == CS_NONE && dly_r == 8'h00));
  assign start_s   = enable_r && !master_select && st_r == ST_IDLE && nss_fall && !sh.busy;
  assign start_any = start_m || start_s;
  assign rx_load   = st_r == ST_XFER && sh.done;
  assign end_desel = master_select && (cur_last_r || (!cur_hold_r && !tx_full_r));

  // Shifter hookup; slave sends back the last received character when nothing new waits
  assign sh.start    = start_any;
  assign sh.abort    = mode_fault_flag_ev || soft_rst;
  assign sh.master   = master_select;
  assign sh.cpol     = sel_cur[SEL_CPOL];
  assign sh.loopback = local_loopback && master_select;
  assign sh.bits     = (sel_cur[SEL_BITS_LO +: 4] > 4'h8) ? BITS_MAX
                       : BITS_BASE + {1'b0, sel_cur[SEL_BITS_LO +: 4]};
  assign sh.scbr     = sel_cur[SEL_SCBR_LO +: 8];
  assign sh.tx_data  = (master_select || tx_full_r) ? tx_data_r : rx_data_r;
  assign sh.miso_s   = s2_r[0];
  assign sh.mosi_s   = s2_r[1];
  assign sh.spck_s   = s2_r[2];
  assign sh.nss_s    = nss_s;

  spm_shifter u_shifter (
    .clk    (clk),
    .resetn (resetn),
    .sh     (sh.eng)
  );

  // Transfer sequencing
  always_ff @(posedge clk) begin
    if (!resetn || soft_rst) begin
      st_r       <= ST_IDLE;
      cur_grp_r  <= 2'h0;
      cur_hold_r <= 1'b0;
      cur_last_r <= 1'b0;
    end else if (mode_fault_flag_ev || (st_r == ST_XFER && !master_select && nss_rise)) begin
      st_r <= ST_IDLE;
    end else if (start_any) begin
      st_r       <= ST_XFER;
      cur_grp_r  <= new_grp;
      cur_hold_r <= sel_r[new_grp][SEL_HOLD];
      cur_last_r <= ps && tx_last_r;
    end else if (rx_load) begin
      st_r <= ST_IDLE;
    end
  end

  // Select lines and the gap between two different selects
  always_ff @(posedge clk) begin
    if (!resetn || soft_rst) begin
      cs_r    <= CS_NONE;
      dly_r   <= 8'h00;
      cs0_q_r <= 2'h3;
    end else begin
      cs0_q_r <= {cs0_q_r[0], cs_r[0]};
      if (mode_fault_flag_ev || desel_m || (rx_load && end_desel)) begin
        cs_r  <= CS_NONE;
        dly_r <= dly_val;
      end else begin
        if (start_m) begin
          cs_r <= new_cs;
        end
        if (dly_r != 8'h00) begin
          dly_r <= dly_r - 8'h01;
        end
      end
    end
  end

  // Enable state; disable wins over enable, a fault drops it
  always_ff @(posedge clk) begin
    if (!resetn || soft_rst) begin
      enable_r <= 1'b0;
    end else if (mode_fault_flag_ev) begin
      enable_r <= 1'b0;
    end else if (wr_ctrl && wdata[CTRL_DIS]) begin
      enable_r <= 1'b0;
    end else if (wr_ctrl && wdata[CTRL_EN]) begin
      enable_r <= 1'b1;
    end
  end

  // Software-written configuration
  always_ff @(posedge clk) begin
    if (!resetn || soft_rst) begin
      mode_r  <= MODE_RESET;
      imask_r <= 10'h000;
      for (int i = 0; i < 4; i++) begin
        sel_r[i] <= SEL_RESET;
      end
    end else if (wr_en) begin
      if (addr == OFF_MODE) begin
        mode_r <= wdata & MODE_MASK;
      end
      if (addr == OFF_IEN) begin
        imask_r <= imask_r | wdata[FLAG_N-1:0];
      end
      if (addr == OFF_IDIS) begin
        imask_r <= imask_r & ~wdata[FLAG_N-1:0];
      end
      for (int i = 0; i < 4; i++) begin
        if (addr == ADDR_W'(OFF_SEL0 + 9'(i * 4))) begin
          sel_r[i] <= wdata;
        end
      end
    end
  end

  // Transmit holding register; the character and select arrive together
  always_ff @(posedge clk) begin
    if (!resetn || soft_rst) begin
      tx_data_r <= 16'h0000;
      tx_pcs_r  <= CS_NONE;
      tx_last_r <= 1'b0;
      tx_full_r <= 1'b0;
    end else if (wr_tx) begin
      tx_data_r <= wdata[15:0];
      tx_pcs_r  <= wdata[MODE_PCS_LO +: 4];
      tx_last_r <= wdata[TX_LAST];
      tx_full_r <= 1'b1;
    end else if (start_any || !enable_r) begin
      tx_full_r <= 1'b0;
    end
  end

  // Receive register: masked character and the select lines seen at the end
  always_ff @(posedge clk) begin
    if (!resetn || soft_rst) begin
      rx_data_r <= 16'h0000;
      rx_pcs_r  <= 4'h0;
    end else if (rx_load) begin
      rx_data_r <= sh.rx_data & 16'((17'h0_0001 << sh.bits) - 17'h0_0001);
      rx_pcs_r  <= master_select ? cs_r : 4'h0;
    end
  end

  // Sticky flags; a set in the clearing cycle wins
  always_ff @(posedge clk) begin
    if (!resetn || soft_rst) begin
      rx_full_r <= 1'b0;
      ovr_r     <= 1'b0;
      mode_fault_flag_r    <= 1'b0;
      slave_select_rising_r    <= 1'b0;
    end else begin
      if (rx_load) begin
        rx_full_r <= 1'b1;
      end else if (rd_rx) begin
        rx_full_r <= 1'b0;
      end
      if (rx_load && rx_full_r && !rd_rx) begin
        ovr_r <= 1'b1;
      end else if (rd_flags) begin
        ovr_r <= 1'b0;
      end
      if (mode_fault_flag_ev) begin
        mode_fault_flag_r <= 1'b1;
      end else if (rd_flags) begin
        mode_fault_flag_r <= 1'b0;
      end
      if (nss_rise) begin
        slave_select_rising_r <= 1'b1;
      end else if (rd_flags) begin
        slave_select_rising_r <= 1'b0;
      end
    end
  end

  // Idle once enabled and holding register, shifter and gap are done; clear out of reset
  always_ff @(posedge clk) begin
    if (!resetn || soft_rst) begin
      txidle_r <= 1'b0;
    end else if (wr_tx) begin
      txidle_r <= 1'b0;
    end else if (enable_r && st_r == ST_IDLE && !tx_full_r && !sh.busy && dly_r == 8'h00) begin
      txidle_r <= 1'b1;
    end
  end

  // Receive and transmit character counters with their next counts
  assign cnt_ev = {start_m || start_s, rx_load};
  for (genvar g = 0; g < 2; g++) begin : g_cnt
    always_ff @(posedge clk) begin
      if (!resetn) begin
        cnt_r[g]  <= 16'h0000;
        ncnt_r[g] <= 16'h0000;
      end else if (wr_en && addr == ADDR_W'(OFF_CNT0 + 9'(g) * CNT_STRIDE)) begin
        cnt_r[g] <= wdata[15:0];
      end else if (wr_en && addr == ADDR_W'(OFF_CNT0 + 9'(g) * CNT_STRIDE + NCNT_OFS)) begin
        ncnt_r[g] <= wdata[15:0];
      end else if (cnt_r[g] == 16'h0000 && ncnt_r[g] != 16'h0000) begin
        cnt_r[g]  <= ncnt_r[g];
        ncnt_r[g] <= 16'h0000;
      end else if (cnt_ev[g] && cnt_r[g] != 16'h0000) begin
        cnt_r[g] <= cnt_r[g] - 16'h0001;
      end
    end
  end

  // Flag word as software sees it
  assign flags = {txidle_r, slave_select_rising_r,
                  cnt_r[1] == 16'h0000 && ncnt_r[1] == 16'h0000,
                  cnt_r[0] == 16'h0000 && ncnt_r[0] == 16'h0000,
                  cnt_r[1] == 16'h0000, cnt_r[0] == 16'h0000,
                  ovr_r, mode_fault_flag_r, enable_r && !tx_full_r, rx_full_r};

  // Read data one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rdata_r <= 32'h0000_0000;
    end else if (rd_en) begin
      case (addr)
        OFF_MODE:  rdata_r <= mode_r;
        OFF_RX:    rdata_r <= {12'h000, rx_pcs_r, rx_data_r};
        OFF_FLAGS: rdata_r <= 32'(flags) | (32'(enable_r) << FLAG_ENS);
        OFF_IMASK: rdata_r <= 32'(imask_r);
        default:   rdata_r <= 32'h0000_0000;
      endcase
      for (int i = 0; i < 4; i++) begin
        if (addr == ADDR_W'(OFF_SEL0 + 9'(i * 4))) begin
          rdata_r <= sel_r[i];
        end
      end
      for (int i = 0; i < 4; i++) begin
        if (addr == ADDR_W'(OFF_CNT0 + 9'(i) * NCNT_OFS)) begin
          rdata_r <= {16'h0000, i[0] ? ncnt_r[i/2] : cnt_r[i/2]};
        end
      end
    end
  end

  // Interrupt line and pin enables; a disabled port leaves every pin an input
  always_ff @(posedge clk) begin
    if (!resetn) begin
      irq_r     <= 1'b0;
      spck_oe_r <= 1'b0;
      mosi_oe_r <= 1'b0;
      miso_oe_r <= 1'b0;
      cs_oe_r   <= 1'b0;
    end else begin
      irq_r     <= |(flags & imask_r);
      spck_oe_r <= enable_r && master_select;
      mosi_oe_r <= enable_r && master_select;
      cs_oe_r   <= enable_r && master_select;
      miso_oe_r <= enable_r && !master_select && !nss_s;
    end
  end

  assign rdata    = rdata_r;
  assign irq      = irq_r;
  assign spck_out = sh.sclk;
  assign spck_oe  = spck_oe_r;
  assign mosi_out = sh.sdo;
  assign mosi_oe  = mosi_oe_r;
  assign miso_out = sh.sdo;
  assign miso_oe  = miso_oe_r;
  assign cs_n_out = cs_r;
  assign cs_oe    = cs_oe_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_desel;
    desel_m && !mode_fault_flag_ev && !soft_rst;
  endsequence
  sequence s_load_full;
    rx_load && rx_full_r && !rd_rx && !soft_rst;
  endsequence

  chk_gap_floor: assert property (s_desel |=> cs_r == CS_NONE && dly_r >= MIN_DLY)
    else $error("select gap shorter than floor");
  chk_plain_onehot: assert property (st_r == ST_XFER && master_select && !dec && cs_r != CS_NONE
    |-> $countones(~cs_r) == 1)
    else $error("plain select not one low line");
  chk_dec_direct: assert property (start_m && dec && !soft_rst && !mode_fault_flag_ev
    |=> cs_r == $past(new_pcs))
    else $error("decoded select differs from field");
  chk_rxfull_set: assert property (rx_load && !soft_rst |=> rx_full_r)
    else $error("receive full not set on load");
  chk_overrun_set: assert property (s_load_full |=> ovr_r ##1 ovr_r || $past(rd_flags))
    else $error("overrun lost");
  chk_fault_off: assert property (mode_fault_flag_ev |=> !enable_r && mode_fault_flag_r && cs_r == CS_NONE)
    else $error("mode fault left port enabled");
  chk_slave_pcs: assert property (rx_load && !master_select && !soft_rst |=> rx_pcs_r == 4'h0)
    else $error("slave select bits not zero");
  chk_idle_clear: assert property (wr_tx && !soft_rst |=> !txidle_r)
    else $error("idle flag survived data write");
  chk_nss_rise: assert property (nss_rise && !soft_rst |=> slave_select_rising_r)
    else $error("select rise not flagged");
  chk_fault_ignored: assert property (mode_fault_disable && enable_r && !wr_ctrl |=> enable_r)
    else $error("fault dropped enable while detection disabled");
endmodule // spm_regs

// [src/spm_pkg.sv]
// Shared constants and types of the serial port register block
package spm_pkg;
  localparam int          ADDR_W      = 9;
  localparam logic [8:0]  OFF_CTRL    = 9'h000;
  localparam logic [8:0]  OFF_MODE    = 9'h004;
  localparam logic [8:0]  OFF_RX      = 9'h008;
  localparam logic [8:0]  OFF_TX      = 9'h00C;
  localparam logic [8:0]  OFF_FLAGS   = 9'h010;
  localparam logic [8:0]  OFF_IEN     = 9'h014;
  localparam logic [8:0]  OFF_IDIS    = 9'h018;
  localparam logic [8:0]  OFF_IMASK   = 9'h01C;
  localparam logic [8:0]  OFF_SEL0    = 9'h030;
  localparam logic [8:0]  OFF_CNT0    = 9'h100;
  localparam logic [8:0]  CNT_STRIDE  = 9'h008;
  localparam logic [8:0]  NCNT_OFS    = 9'h004;
  // Control word bits
  localparam int CTRL_EN = 0;
  localparam int CTRL_DIS = 1;
  localparam int CTRL_SWRST = 7;
  // Mode word fields
  localparam int MODE_MASTER_SELECT = 0;
  localparam int MODE_PS = 1;
  localparam int MODE_DEC = 2;
  localparam int MODE_MODE_FAULT_DISABLE = 4;
  localparam int MODE_LLB = 7;
  localparam int MODE_PCS_LO = 16;
  localparam int MODE_DLY_LO = 24;
  localparam logic [31:0] MODE_RESET = 32'h0000_0000;
  localparam logic [31:0] MODE_MASK  = 32'hFF0F_0097;
  localparam int TX_LAST = 24;
  // Per-select settings fields
  localparam int SEL_CPOL = 0;
  localparam int SEL_HOLD = 3;
  localparam int SEL_BITS_LO = 4;
  localparam int SEL_SCBR_LO = 8;
  localparam logic [31:0] SEL_RESET = 32'h0000_0000;
  localparam logic [4:0]  BITS_BASE = 5'h08;
  localparam logic [4:0]  BITS_MAX  = 5'h10;
  // Flag word bits
  localparam int FLAG_N = 10;
  localparam int FLAG_ENS = 16;
  localparam logic [7:0] MIN_DLY = 8'h06;
  localparam logic [3:0] CS_NONE = 4'hF;
  typedef enum logic [0:0] {ST_IDLE = 1'b0, ST_XFER = 1'b1} spm_state_t;
endpackage

// [src/spm_shift_if.sv]
// Signals between the register block and its character shifter
interface spm_shift_if;
  logic        start;
  logic        abort;
  logic        master;
  logic        cpol;
  logic        loopback;
  logic [4:0]  bits;
  logic [7:0]  scbr;
  logic [15:0] tx_data;
  logic        miso_s;
  logic        mosi_s;
  logic        spck_s;
  logic        nss_s;
  logic        busy;
  logic        done;
  logic        sclk;
  logic        sdo;
  logic [15:0] rx_data;
  modport ctl (output start, abort, master, cpol, loopback, bits, scbr, tx_data,
               miso_s, mosi_s, spck_s, nss_s, input busy, done, sclk, sdo, rx_data);
  modport eng (input start, abort, master, cpol, loopback, bits, scbr, tx_data,
               miso_s, mosi_s, spck_s, nss_s, output busy, done, sclk, sdo, rx_data);
endinterface

// [src/spm_shifter.sv]
// Character shifter: makes the serial clock as master, follows it as slave
module spm_shifter (
  input wire logic clk,
  input wire logic resetn,
  spm_shift_if.eng sh
);
  import spm_pkg::*;

  logic        busy_r;
  logic        done_r;
  logic        sclk_r;
  logic        sdo_r;
  logic        samp_r;
  logic        prev_r;
  logic [4:0]  cnt_r;
  logic [7:0]  div_r;
  logic [15:0] shreg_r;
  logic [7:0]  half;
  logic        tick;
  logic        lead;
  logic        trail;
  logic        sdi;

  // Master half period; one cycle floor keeps a zero baud field alive
  assign half  = (sh.scbr > 8'h01) ? {1'b0, sh.scbr[7:1]} : 8'h01;
  assign tick  = sh.master && (div_r == 8'h01);
  // Capture on the leading edge, change on the trailing one
  assign lead  = sh.master ? (tick && sclk_r == sh.cpol)
                           : (sh.spck_s != prev_r && sh.spck_s != sh.cpol);
  assign trail = sh.master ? (tick && sclk_r != sh.cpol)
                           : (sh.spck_s != prev_r && sh.spck_s == sh.cpol);
  assign sdi   = sh.master ? (sh.loopback ? sdo_r : sh.miso_s) : sh.mosi_s;

  // Shift sequence, most significant bit first
  always_ff @(posedge clk) begin
    if (!resetn) begin
      busy_r  <= 1'b0;
      done_r  <= 1'b0;
      sclk_r  <= 1'b0;
      sdo_r   <= 1'b0;
      samp_r  <= 1'b0;
      prev_r  <= 1'b0;
      cnt_r   <= 5'h00;
      div_r   <= 8'h01;
      shreg_r <= 16'h0000;
    end else begin
      done_r <= 1'b0;
      prev_r <= sh.spck_s;
      if (sh.abort) begin
        busy_r <= 1'b0;
        sclk_r <= sh.cpol;
      end else if (sh.start && !busy_r) begin
        busy_r  <= 1'b1;
        shreg_r <= sh.tx_data;
        cnt_r   <= sh.bits;
        div_r   <= half;
        sclk_r  <= sh.cpol;
        sdo_r   <= sh.tx_data[4'(sh.bits - 5'h01)];
      end else if (busy_r) begin
        if (!sh.master && sh.nss_s) begin
          busy_r <= 1'b0;
        end else begin
          if (sh.master) begin
            div_r <= tick ? half : div_r - 8'h01;
            if (tick) begin
              sclk_r <= ~sclk_r;
            end
          end
          if (lead) begin
            samp_r <= sdi;
          end
          if (trail) begin
            shreg_r <= {shreg_r[14:0], samp_r};
            sdo_r   <= shreg_r[4'(sh.bits - 5'h02)];
            cnt_r   <= cnt_r - 5'h01;
            if (cnt_r == 5'h01) begin
              busy_r <= 1'b0;
              done_r <= 1'b1;
            end
          end
        end
      end else begin
        sclk_r <= sh.cpol;
      end
    end
  end

  assign sh.busy    = busy_r;
  assign sh.done    = done_r;
  assign sh.sclk    = sclk_r;
  assign sh.sdo     = sdo_r;
  assign sh.rx_data = shreg_r;
endmodule // spm_shifter

// [testbench/spm_slave_model.sv]
// Behavioural serial peripheral answering on the chip-select lines
module spm_slave_model #(
  parameter logic [7:0] REPLY = 8'h5A
) (
  input  wire logic       sck,
  input  wire logic       cs_n,
  input  wire logic       mosi,
  output logic            miso,
  output logic [7:0]      got
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] sh = 8'h00;
  initial miso = 1'b1;
  initial got = 8'h00;
  // First bit present at selection, changed on trailing edge
  always @(negedge cs_n) begin
    sh = REPLY;
    miso = sh[7];
  end
  always @(posedge sck) if (!cs_n) got = {got[6:0], mosi};
  always @(negedge sck) if (!cs_n) begin
    sh = {sh[6:0], 1'b0};
    miso = sh[7];
  end
  // Released line floats up to its pull-up
  always @(posedge cs_n) miso = 1'b1;
endmodule // spm_slave_model

// [testbench/testbench.sv]
// Self-checking bench for the serial port register block
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import spm_pkg::*;
  logic        clk = 0, resetn = 0, wr_en = 0, rd_en = 0;
  logic        spck_in = 0, mosi_in = 0, nss_in = 1;
  logic [8:0]  addr = '0;
  logic [31:0] wdata = '0, rdata, acc, d;
  logic        spck_out, mosi_out, miso, irq, so;
  logic [3:0]  cs_n_out, cs_seen, oe;
  logic [7:0]  got, sent;
  int          miscompares = 0, checks = 0;
  spm_regs u_spm_regs (.clk, .resetn, .addr, .wdata, .wr_en, .rd_en, .rdata, .irq,
    .spck_in, .spck_out, .spck_oe(oe[0]), .mosi_in, .mosi_out, .mosi_oe(oe[1]),
    .miso_in(miso), .miso_out(so), .miso_oe(oe[2]), .nss_in, .cs_n_out, .cs_oe(oe[3]));
  spm_slave_model u_spm_slave_model (.sck(spck_out), .cs_n(&cs_n_out), .mosi(mosi_out),
    .miso, .got);
  always #50 clk = ~clk;
  task wr(input logic [8:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr_en <= 1;
    @(posedge clk);
    wr_en <= 0;
  endtask
  task rd(input logic [8:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd_en <= 1;
    @(posedge clk);
    rd_en <= 0;
    #1 v = rdata;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Masked register compare
  task rc(input logic [8:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] v;
    rd(a, v);
    chk(v & m, e);
  endtask
  // Send one character, poll flags until drained; flags gathered since reads clear some
  task xfer(input logic [31:0] v);
    logic [31:0] f;
    f = '0;
    acc = '0;
    cs_seen = 4'hF;
    wr(OFF_TX, v);
    for (int i = 0; i < 400 && !(f[9] && acc[0]); i++) begin
      rd(OFF_FLAGS, f);
      acc |= f;
      if (cs_n_out !== 4'hF) cs_seen = cs_n_out;
    end
  endtask
  // Slave character on an 800 ns link clock; our outgoing bit is taken before each rise
  task send_slave(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      mosi_in <= b[i];
      repeat (4) @(posedge clk);
      sent = {sent[6:0], so};
      spck_in <= 1;
      repeat (4) @(posedge clk);
      spck_in <= 0;
    end
  endtask
  task report_and_stop;
    if (miscompares == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Generous bound: whole sequence needs well under a millisecond
  initial begin
    #2_000_000;
    miscompares++;
    report_and_stop;
  end
  initial begin
    repeat (8) @(posedge clk);
    resetn <= 1;
    rc(OFF_MODE, 32'hFFFF_FFFF, 32'h0000_0000);
    rc(OFF_FLAGS, 32'hFFFF_FFFF, 32'h0000_00F0);
    rc(9'h020, 32'hFFFF_FFFF, 32'h0000_0000);
    rc(OFF_TX, 32'hFFFF_FFFF, 32'h0000_0000);
    // Every settings word: hold set, four-cycle half period
    for (int i = 0; i < 4; i++) begin
      wr(OFF_SEL0 + 9'(4 * i), 32'h0000_0808);
    end
    wr(OFF_MODE, 32'h0001_0001);
    wr(OFF_CTRL, 32'h0000_0001);
    rc(OFF_FLAGS, 32'h0001_0002, 32'h0001_0002);
    chk({28'h0, oe}, 32'h0000_000B);
    xfer(32'h0000_00A5);
    chk({28'h0, cs_seen}, 32'h0000_000D);
    chk({24'h0, got}, 32'h0000_00A5);
    rc(OFF_RX, 32'hFFFF_FFFF, 32'h000D_005A);
    rc(OFF_FLAGS, 32'h0000_0001, 32'h0000_0000);
    xfer(32'h0000_0011);
    xfer(32'h0000_0022);
    chk({31'h0, acc[3]}, 32'h0000_0001);
    rc(OFF_FLAGS, 32'h0000_0008, 32'h0000_0000);
    wr(OFF_MODE, 32'h0001_0081);
    xfer(32'h0000_003C);
    rc(OFF_RX, 32'hFFFF_FFFF, 32'h000D_003C);
    wr(OFF_MODE, 32'h0000_0003);
    for (int i = 0; i < 4; i++) begin
      xfer(32'h0100_0000 | ((32'h1 << i) - 1) << 16 | i);
      chk({28'h0, cs_seen}, {28'h0, ~(4'h1 << i)});
      chk({28'h0, cs_n_out}, 32'h0000_000F);
    end
    wr(OFF_MODE, 32'h0009_0005);
    xfer(32'h0000_0055);
    chk({28'h0, cs_seen}, 32'h0000_0009);
    wr(OFF_MODE, 32'h0001_0011);
    wr(OFF_IEN, 32'h0000_0004);
    nss_in <= 0;
    repeat (10) @(posedge clk);
    rc(OFF_FLAGS, 32'h0001_0004, 32'h0001_0000);
    wr(OFF_MODE, 32'h0001_0001);
    repeat (10) @(posedge clk);
    chk({27'h0, irq, oe}, 32'h0000_0010);
    rc(OFF_FLAGS, 32'h0001_0004, 32'h0000_0004);
    rc(OFF_FLAGS, 32'h0000_0004, 32'h0000_0000);
    nss_in <= 1;
    wr(OFF_MODE, 32'h0000_0000);
    wr(OFF_CTRL, 32'h0000_0001);
    rc(OFF_RX, 32'hFFFF_FFFF, 32'h0009_005A);
    nss_in <= 0;
    repeat (4) @(posedge clk);
    chk({28'h0, oe}, 32'h0000_0004);
    send_slave(8'hC3);
    repeat (8) @(posedge clk);
    nss_in <= 1;
    repeat (8) @(posedge clk);
    rc(OFF_RX, 32'hFFFF_FFFF, 32'h0000_00C3);
    chk({24'h0, sent}, 32'h0000_005A);
    rc(OFF_FLAGS, 32'h0000_0100, 32'h0000_0100);
    report_and_stop;
  end
endmodule // testbench
